/* File: src/timer_pkg.sv */
// Constants, field layouts and carrier types of the timer event block
package timer_pkg;

  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          NUM_GR         = 4;

  // Register byte offsets
  localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_IO_CONTROL = 8'h08;
  localparam logic [7:0]  OFS_COUNTER    = 8'h0C;
  localparam logic [7:0]  OFS_GR_A       = 8'h10;
  localparam logic [7:0]  OFS_GR_B       = 8'h14;
  localparam logic [7:0]  OFS_GR_C       = 8'h18;
  localparam logic [7:0]  OFS_GR_D       = 8'h1C;
  localparam logic [7:0]  OFS_RUN_CTRL   = 8'h20;

  // Field positions
  localparam int          OVF_BIT        = 7;
  localparam int          ROLE_B_BIT     = 6;
  localparam int          ACT_B_LO       = 4;
  localparam int          ROLE_A_BIT     = 2;
  localparam int          ACT_A_LO       = 0;
  localparam int          RUN_BIT        = 0;

  // Bits that always read as one
  localparam logic [7:0]  EVT_ONES       = 8'h70;
  localparam logic [7:0]  IO_ONES        = 8'h88;

  // Reset values and the counter's top count
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  localparam logic [15:0] GR_RESET       = 16'hFFFF;
  localparam logic [5:0]  IO_RESET       = 6'h00;

  // Compare actions and capture edges
  localparam logic [1:0]  ACT_NONE       = 2'h0;
  localparam logic [1:0]  ACT_LOW        = 2'h1;
  localparam logic [1:0]  ACT_HIGH       = 2'h2;
  localparam logic [1:0]  ACT_TOGGLE     = 2'h3;
  localparam logic [1:0]  EDGE_RISE      = 2'h0;
  localparam logic [1:0]  EDGE_FALL      = 2'h1;

  typedef struct packed {
    logic       capture;
    logic [1:0] action;
  } chan_cfg_t;

endpackage

/* File: src/timer_flag.sv */
// One status flag with read-then-write-zero clearing
`timescale 1ns/1ps
module timer_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_event,
  input  wire logic read_seen,
  input  wire logic write_zero,
  output logic      flag
);

  logic armed;

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set_event) begin
      flag <= 1'b1;
    end else if (write_zero && armed) begin
      flag <= 1'b0;
    end
  end

  // A read that saw the flag high arms the next zero write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (write_zero) begin
      armed <= 1'b0;
    end else if (read_seen) begin
      armed <= 1'b1;
    end
  end

  AST_FLAG_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    set_event |=> flag)
    else $error("flag lost a set event");

  AST_FLAG_NEEDS_ARM: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(flag) |-> $past(armed) && $past(write_zero))
    else $error("flag cleared without prior read");

endmodule

/* File: src/timer_chan.sv */
// One general register channel: output compare or input capture
`timescale 1ns/1ps
module timer_chan (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire timer_pkg::chan_cfg_t cfg,
  input  wire logic [15:0]         count,
  input  wire logic                count_tick,
  input  wire logic                gr_wr,
  input  wire logic [15:0]         gr_wdata,
  input  wire logic                pin_in,
  output logic [15:0]              gr,
  output logic                     event_hit,
  output logic                     pin_out,
  output logic                     pin_oe
);

  logic pin_prev;
  logic rise;
  logic fall;
  logic edge_hit;
  logic match;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_in;
    end
  end

  assign rise = pin_in && !pin_prev;
  assign fall = !pin_in && pin_prev;

  always_comb begin
    if (cfg.action[1]) begin
      edge_hit = cfg.capture && (rise || fall);
    end else if (cfg.action == timer_pkg::EDGE_FALL) begin
      edge_hit = cfg.capture && fall;
    end else begin
      edge_hit = cfg.capture && rise;
    end
  end

  // Match is gated by count_tick (counter running), so a halted counter gives no match event
  assign match     = !cfg.capture && count_tick && (count == gr);
  assign event_hit = match || edge_hit;

  // Capture beats a software write landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gr <= timer_pkg::GR_RESET;
    end else if (edge_hit) begin
      gr <= count;
    end else if (gr_wr) begin
      gr <= gr_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
    end else if (match) begin
      unique case (cfg.action)
        timer_pkg::ACT_NONE:   pin_out <= pin_out;
        timer_pkg::ACT_LOW:    pin_out <= 1'b0;
        timer_pkg::ACT_HIGH:   pin_out <= 1'b1;
        timer_pkg::ACT_TOGGLE: pin_out <= !pin_out;
      endcase
    end
  end

  assign pin_oe = !cfg.capture;

  AST_CAPTURE_LOADS: assert property (@(posedge pclk) disable iff (!presetn)
    edge_hit |=> gr == $past(count))
    else $error("capture did not load the counter value");

  AST_TOGGLE_ACT: assert property (@(posedge pclk) disable iff (!presetn)
    match && cfg.action == timer_pkg::ACT_TOGGLE
      |=> pin_out != $past(pin_out))
    else $error("toggle action did not invert the pin");

endmodule

/* File: src/timer_irq_status_io_ctrl.sv */
// Timer interrupt enable, event status and channel A/B pin control
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module timer_irq_status_io_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chan_a_pin_in,
  output logic             chan_a_pin_out,
  output logic             chan_a_pin_oe,
  input  wire logic        chan_b_pin_in,
  output logic             chan_b_pin_out,
  output logic             chan_b_pin_oe,
  output logic             overflow_irq_request,
  output logic             match_irq_request_a,
  output logic             match_irq_request_b,
  output logic             match_irq_request_c,
  output logic             match_irq_request_d,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                    overflow_irq_enable;
  logic [3:0]              match_irq_enable;
  logic                    chan_b_role_select;
  logic [1:0]              chan_b_action;
  logic                    chan_a_role_select;
  logic [1:0]              chan_a_action;
  logic                    counter_run;
  logic [15:0]             up_counter;
  logic                    overflow_flag;
  logic [3:0]              match_flag;
  logic [3:0]              match_event;
  logic [15:0]             general_reg [timer_pkg::NUM_GR];
  logic [3:0]              gr_wr;
  logic [3:0]              pin_in_vec;
  logic [3:0]              pin_out_vec;
  logic [3:0]              pin_oe_vec;
  timer_pkg::chan_cfg_t    chan_cfg [timer_pkg::NUM_GR];
  logic                    setup;
  logic                    access;
  logic                    wr_done;
  logic                    rd_done;
  logic                    hit;
  logic [31:0]             next_prdata;
  logic [7:0]              irq_enable_rd;
  logic [7:0]              status_rd;
  logic [7:0]              io_control_rd;
  logic                    status_wr;
  logic                    status_rd_done;
  logic                    overflow_event;
  logic [4:0]              flag_set;
  logic [4:0]              flag_rd_seen;
  logic [4:0]              flag_wr_zero;
  logic [4:0]              flag_vec;
  logic                    counter_wr;
  logic                    ovf_read_seen;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, data latched in the setup phase

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign wr_done = access && pwrite && !pslverr;
  assign rd_done = access && !pwrite && !pslverr;

  assign irq_enable_rd = {overflow_irq_enable, 3'h0, match_irq_enable}
                         | timer_pkg::EVT_ONES;
  assign status_rd     = {overflow_flag, 3'h0, match_flag}
                         | timer_pkg::EVT_ONES;
  assign io_control_rd = {1'b0, chan_b_role_select, chan_b_action,
                          1'b0, chan_a_role_select, chan_a_action}
                         | timer_pkg::IO_ONES;

  always_comb begin
    next_prdata = 32'h0000_0000;
    hit         = 1'b1;
    unique case (paddr)
      timer_pkg::OFS_IRQ_ENABLE: next_prdata[7:0]  = irq_enable_rd;
      timer_pkg::OFS_STATUS:     next_prdata[7:0]  = status_rd;
      timer_pkg::OFS_IO_CONTROL: next_prdata[7:0]  = io_control_rd;
      timer_pkg::OFS_COUNTER:    next_prdata[15:0] = up_counter;
      timer_pkg::OFS_GR_A:       next_prdata[15:0] = general_reg[0];
      timer_pkg::OFS_GR_B:       next_prdata[15:0] = general_reg[1];
      timer_pkg::OFS_GR_C:       next_prdata[15:0] = general_reg[2];
      timer_pkg::OFS_GR_D:       next_prdata[15:0] = general_reg[3];
      timer_pkg::OFS_RUN_CTRL:   next_prdata[0]    = counter_run;
      default:                   hit               = 1'b0;
    endcase
  end

  // Data is snapshotted in setup so the flag arm below sees what was read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable <= 1'b0;
      match_irq_enable    <= 4'h0;
    end else if (wr_done && paddr == timer_pkg::OFS_IRQ_ENABLE) begin
      overflow_irq_enable <= pwdata[timer_pkg::OVF_BIT];
      match_irq_enable    <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {chan_b_role_select, chan_b_action,
       chan_a_role_select, chan_a_action} <= timer_pkg::IO_RESET;
    end else if (wr_done && paddr == timer_pkg::OFS_IO_CONTROL) begin
      chan_b_role_select <= pwdata[timer_pkg::ROLE_B_BIT];
      chan_b_action      <= pwdata[timer_pkg::ACT_B_LO +: 2];
      chan_a_role_select <= pwdata[timer_pkg::ROLE_A_BIT];
      chan_a_action      <= pwdata[timer_pkg::ACT_A_LO +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_run <= 1'b0;
    end else if (wr_done && paddr == timer_pkg::OFS_RUN_CTRL) begin
      counter_run <= pwdata[timer_pkg::RUN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter: counts every pclk while running; a software write wins

  assign counter_wr     = wr_done && paddr == timer_pkg::OFS_COUNTER;

  // A software write in the wrap cycle replaces the count, so no wrap
  assign overflow_event = counter_run
                          && up_counter == timer_pkg::COUNT_MAX
                          && !counter_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_counter <= timer_pkg::COUNT_RESET;
    end else if (counter_wr) begin
      up_counter <= pwdata[15:0];
    end else if (counter_run) begin
      up_counter <= up_counter + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General register channels; C and D have no pin control here

  assign pin_in_vec = {2'h0, chan_b_pin_in, chan_a_pin_in};

  assign chan_cfg[0] = '{capture: chan_a_role_select, action: chan_a_action};
  assign chan_cfg[1] = '{capture: chan_b_role_select, action: chan_b_action};
  assign chan_cfg[2] = '{capture: 1'b0, action: timer_pkg::ACT_NONE};
  assign chan_cfg[3] = '{capture: 1'b0, action: timer_pkg::ACT_NONE};

  for (genvar i = 0; i < timer_pkg::NUM_GR; i++) begin : g_chan
    assign gr_wr[i] = wr_done
                      && paddr == timer_pkg::OFS_GR_A + 8'(4 * i);
    timer_chan u_chan (
      .pclk       (pclk),
      .presetn    (presetn),
      .cfg        (chan_cfg[i]),
      .count      (up_counter),
      .count_tick (counter_run),
      .gr_wr      (gr_wr[i]),
      .gr_wdata   (pwdata[15:0]),
      .pin_in     (pin_in_vec[i]),
      .gr         (general_reg[i]),
      .event_hit  (match_event[i]),
      .pin_out    (pin_out_vec[i]),
      .pin_oe     (pin_oe_vec[i])
    );
  end

  assign chan_a_pin_out = pin_out_vec[0];
  assign chan_a_pin_oe  = pin_oe_vec[0];
  assign chan_b_pin_out = pin_out_vec[1];
  assign chan_b_pin_oe  = pin_oe_vec[1];

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: bit 4 is overflow, bits 3..0 are matches D..A

  assign status_wr      = wr_done && paddr == timer_pkg::OFS_STATUS;
  assign status_rd_done = rd_done && paddr == timer_pkg::OFS_STATUS;
  assign flag_set       = {overflow_event, match_event};

  // Arming uses the value returned, not the live flag
  assign flag_rd_seen = {5{status_rd_done}}
                        & {prdata[timer_pkg::OVF_BIT], prdata[3:0]};
  // A one written leaves the flag alone
  assign flag_wr_zero = {5{status_wr}}
                        & ~{pwdata[timer_pkg::OVF_BIT], pwdata[3:0]};

  for (genvar f = 0; f < 5; f++) begin : g_flag
    timer_flag u_flag (
      .pclk       (pclk),
      .presetn    (presetn),
      .set_event  (flag_set[f]),
      .read_seen  (flag_rd_seen[f]),
      .write_zero (flag_wr_zero[f]),
      .flag       (flag_vec[f])
    );
  end

  assign overflow_flag = flag_vec[4];
  assign match_flag    = flag_vec[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests; the enable register doubles as the mask

  assign overflow_irq_request = overflow_flag && overflow_irq_enable;
  assign match_irq_request_a  = match_flag[0] && match_irq_enable[0];
  assign match_irq_request_b  = match_flag[1] && match_irq_enable[1];
  assign match_irq_request_c  = match_flag[2] && match_irq_enable[2];
  assign match_irq_request_d  = match_flag[3] && match_irq_enable[3];
  assign irq = overflow_irq_request || match_irq_request_a
               || match_irq_request_b || match_irq_request_c
               || match_irq_request_d;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Shadow of read-while-set, kept apart from the flag cell so the
  // check below does not lean on the logic that it guards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_read_seen <= 1'b0;
    end else if (status_wr && !pwdata[timer_pkg::OVF_BIT]) begin
      ovf_read_seen <= 1'b0;
    end else if (status_rd_done && overflow_flag) begin
      ovf_read_seen <= 1'b1;
    end
  end

  AST_OVF_REQ: assert property (
    overflow_event && overflow_irq_enable
    && !(wr_done && paddr == timer_pkg::OFS_IRQ_ENABLE)
    |=> overflow_irq_request)
    else $error("overflow request missing after a wrap");

  AST_MATCH_REQ_A: assert property (
    match_event[0] && match_irq_enable[0]
    && !(wr_done && paddr == timer_pkg::OFS_IRQ_ENABLE)
    |=> match_irq_request_a)
    else $error("match request a missing after its event");

  AST_MATCH_REQ_GATED: assert property (
    !match_irq_enable[2] |-> !match_irq_request_c)
    else $error("masked match request c leaked");

  AST_EVT_ONES: assert property (
    setup && !pwrite && (paddr == timer_pkg::OFS_STATUS
      || paddr == timer_pkg::OFS_IRQ_ENABLE)
    |=> prdata[6:4] == 3'h7)
    else $error("reserved status or enable bits not read as one");

  AST_WRAP_SETS_OVF: assert property (
    counter_run && up_counter == timer_pkg::COUNT_MAX
    && !(wr_done && paddr == timer_pkg::OFS_COUNTER)
    |=> up_counter == timer_pkg::COUNT_RESET && overflow_flag)
    else $error("counter wrap did not set the overflow flag");

  AST_OVF_NO_BLIND_CLEAR: assert property (
    $fell(overflow_flag) |-> $past(ovf_read_seen) && $past(status_wr)
    && !$past(pwdata[timer_pkg::OVF_BIT]))
    else $error("overflow flag cleared without a read while set");

  AST_COUNT_STEP: assert property (
    counter_run && !counter_wr
    |=> up_counter == $past(up_counter) + 16'h0001)
    else $error("running counter did not step by one");

  AST_COUNT_HOLD: assert property (
    !counter_run && !counter_wr |=> $stable(up_counter))
    else $error("halted counter moved");

  AST_MATCH_A_SETS: assert property (
    !chan_a_role_select && counter_run && up_counter == general_reg[0]
    |=> match_flag[0])
    else $error("compare match a did not set its flag");

  AST_MATCH_B_SETS: assert property (
    !chan_b_role_select && counter_run && up_counter == general_reg[1]
    |=> match_flag[1])
    else $error("compare match b did not set its flag");

  AST_CAPTURE_SETS: assert property (
    chan_a_role_select && match_event[0] |=> match_flag[0])
    else $error("capture a did not set its flag");

  AST_IO_ONES: assert property (
    setup && !pwrite && paddr == timer_pkg::OFS_IO_CONTROL
    |=> prdata[7] && prdata[3])
    else $error("reserved control bits not read as one");

  AST_OE_ROLE_B: assert property (
    chan_b_pin_oe == !chan_b_role_select)
    else $error("channel b drive does not follow its role");

  AST_ONE_WRITE_KEEPS: assert property (
    match_flag[1] && status_wr && pwdata[1] |=> match_flag[1])
    else $error("writing one cleared a match flag");

  COV_OVF_IRQ: cover property (overflow_irq_request);
  COV_CAPTURE_A: cover property (chan_a_role_select && match_event[0]);
  COV_FLAG_CLEAR: cover property (status_rd_done ##[1:4] $fell(match_flag[0]));
  COV_TOGGLE_B: cover property ($changed(chan_b_pin_out));

endmodule

/* File: verification/timer_pin_model.sv */
// Far-side pin model: reads back the device drive or a bench level
`timescale 1ns/1ps
module timer_pin_model (
  input  wire logic pclk,
  input  wire logic pin_oe,
  input  wire logic pin_out,
  input  wire logic level,
  output logic      pin
);
  initial pin = 1'b0;
  // One register late, as a pad synchroniser would be
  always @(posedge pclk) begin
    pin <= pin_oe ? pin_out : level;
  end
endmodule

/* File: verification/timer_irq_status_io_ctrl_tb.sv */
// Self-checking bench for the timer event and pin control block
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  errors++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module timer_irq_status_io_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        a_in, a_out, a_oe, b_in, b_out, b_oe, lvl_a, lvl_b, err;
  logic        ovf_req, req_a, req_b, req_c, req_d, irq;
  int          errors, check_count, cyc;
  logic [1:0]  act [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  logic        pin_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  timer_irq_status_io_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_a_pin_in(a_in), .chan_a_pin_out(a_out), .chan_a_pin_oe(a_oe),
    .chan_b_pin_in(b_in), .chan_b_pin_out(b_out), .chan_b_pin_oe(b_oe),
    .overflow_irq_request(ovf_req), .match_irq_request_a(req_a),
    .match_irq_request_b(req_b), .match_irq_request_c(req_c),
    .match_irq_request_d(req_d), .irq(irq));
  timer_pin_model pa (.pclk(pclk), .pin_oe(a_oe), .pin_out(a_out),
    .level(lvl_a), .pin(a_in));
  timer_pin_model pb (.pclk(pclk), .pin_oe(b_oe), .pin_out(b_out),
    .level(lvl_b), .pin(b_in));

  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Tests need about 360 cycles; the ceiling leaves ample slack
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  // Read arms every set flag, then a zero write clears them
  task automatic clr();
    apb(1'b0, timer_pkg::OFS_STATUS, 32'h0000_0000);
    wr(timer_pkg::OFS_STATUS, 32'h0000_0000);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic test_regs();
    rd_chk(timer_pkg::OFS_IRQ_ENABLE, 32'h0000_0070);
    rd_chk(timer_pkg::OFS_STATUS, 32'h0000_0070);
    rd_chk(timer_pkg::OFS_IO_CONTROL, 32'h0000_0088);
    wr(timer_pkg::OFS_IRQ_ENABLE, 32'h0000_008F);
    rd_chk(timer_pkg::OFS_IRQ_ENABLE, 32'h0000_00FF);
    wr(timer_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
    wr(timer_pkg::OFS_IO_CONTROL, 32'h0000_0077);
    rd_chk(timer_pkg::OFS_IO_CONTROL, 32'h0000_00FF);
    wr(timer_pkg::OFS_IO_CONTROL, 32'h0000_0000);
    rd_chk(timer_pkg::OFS_COUNTER, 32'h0000_0000);
    wr(timer_pkg::OFS_COUNTER, 32'h0000_1234);
    rd_chk(timer_pkg::OFS_COUNTER, 32'h0000_1234);
    rd_chk(8'h40, 32'h0000_0000);
    `CHK(err, 1'b1)
    $display("test regs done");
  endtask

  task automatic test_overflow();
    wr(timer_pkg::OFS_COUNTER, 32'h0000_FFFE);
    wr(timer_pkg::OFS_RUN_CTRL, 32'h0000_0001);
    tick(4);
    wr(timer_pkg::OFS_RUN_CTRL, 32'h0000_0000);
    `CHK(ovf_req, 1'b0)
    wr(timer_pkg::OFS_STATUS, 32'h0000_0000);
    apb(1'b0, timer_pkg::OFS_STATUS, 32'h0000_0000);
    `CHK(rd[7], 1'b1)
    `CHK(rd[3:0], 4'hF)
    wr(timer_pkg::OFS_IRQ_ENABLE, 32'h0000_008C);
    `CHK(ovf_req, 1'b1)
    `CHK({req_c, req_d}, 2'b11)
    `CHK({req_a, req_b}, 2'b00)
    `CHK(irq, 1'b1)
    wr(timer_pkg::OFS_STATUS, 32'h0000_0000);
    rd_chk(timer_pkg::OFS_STATUS, 32'h0000_0070);
    `CHK(irq, 1'b0)
    wr(timer_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
    $display("test overflow done");
  endtask

  task automatic test_compare();
    wr(timer_pkg::OFS_GR_A, 32'h0000_0005);
    wr(timer_pkg::OFS_GR_B, 32'h0000_0005);
    wr(timer_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wr(timer_pkg::OFS_COUNTER, 32'h0000_0000);
      wr(timer_pkg::OFS_IO_CONTROL, {26'h0, act[i], 2'h0, act[i]});
      wr(timer_pkg::OFS_RUN_CTRL, 32'h0000_0001);
      tick(12);
      wr(timer_pkg::OFS_RUN_CTRL, 32'h0000_0000);
      `CHK(a_out, pin_exp[i])
      `CHK(b_out, pin_exp[i])
      `CHK(a_oe & b_oe, 1'b1)
      `CHK({req_a, req_b}, 2'b10)
      rd_chk(timer_pkg::OFS_STATUS, 32'h0000_0073);
      clr();
      `CHK(req_a, 1'b0)
    end
    wr(timer_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
    $display("test compare done");
  endtask

  task automatic test_capture();
    for (int m = 0; m < 3; m++) begin
      wr(timer_pkg::OFS_IO_CONTROL, 32'h0000_0044 | (m << 4) | m);
      wr(timer_pkg::OFS_COUNTER, 32'h0000_0100 + m);
      tick(4);
      clr();
      `CHK(a_oe | b_oe, 1'b0)
      lvl_a <= 1'b1;
      lvl_b <= 1'b1;
      tick(4);
      rd_chk(timer_pkg::OFS_STATUS, (m != 1) ? 32'h73 : 32'h70);
      clr();
      lvl_a <= 1'b0;
      lvl_b <= 1'b0;
      tick(4);
      rd_chk(timer_pkg::OFS_STATUS, (m != 0) ? 32'h73 : 32'h70);
      clr();
      rd_chk(timer_pkg::OFS_GR_A, 32'h0000_0100 + m);
      rd_chk(timer_pkg::OFS_GR_B, 32'h0000_0100 + m);
    end
    $display("test capture done");
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    lvl_a   = 1'b0;
    lvl_b   = 1'b0;
    errors = 0;
    check_count = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_regs();
    test_overflow();
    test_compare();
    test_capture();
    wrap_up();
  end
endmodule
